/* File: src/sirx_pkg.sv */
// Shared constants and types for the status and receive data registers
package sirx_pkg;
    // Register addresses on the serial control bus
    localparam logic [7:0] ADDR_AUX = 8'hB4;
    localparam logic [7:0] ADDR_RXLO = 8'hC5;
    localparam logic [7:0] ADDR_STAT = 8'hC6;
    localparam logic [7:0] ADDR_PROG = 8'hC8;
    localparam logic [7:0] ADDR_RXHI = 8'hC9;
    localparam logic [7:0] ADDR_MASK = 8'hCE;
    // Broadcast tone-set address
    localparam logic [7:0] ALL_CALL = 8'h40;
    // Status word field positions
    localparam int B_IRQ = 15;
    localparam int B_INB = 13;
    localparam int B_TSET = 12;
    localparam int B_CTC = 11;
    localparam int B_DCS = 10;
    localparam int B_AHI = 9;
    localparam int B_ALO = 8;
    localparam int B_END = 7;
    localparam int B_XFER = 6;
    localparam int B_CRC = 5;
    localparam int B_R24 = 4;
    localparam int B_R12 = 3;
    localparam int B_PROG = 0;
    localparam logic [15:0] CLEAR_ON_READ = 16'hFFFE;
    localparam logic [15:0] RSVD_MASK = 16'h4006;
    localparam logic [15:0] TONE_FLAGS = 16'h2C00;
    localparam logic [15:0] STAT_RST = 16'h0001;
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0] AUX_RST = 8'h00;
    // Serial frame bit counts
    localparam logic [4:0] CNT_ADDR = 5'h08;
    localparam logic [4:0] CNT_BYTE = 5'h10;
    localparam logic [4:0] CNT_WORD = 5'h18;
    // Modem data formats
    localparam logic [2:0] FMT_0 = 3'h0;
    localparam logic [2:0] FMT_2 = 3'h2;
    localparam logic [2:0] FMT_3 = 3'h3;
    localparam logic [2:0] FMT_4 = 3'h4;
    localparam logic [2:0] FMT_5 = 3'h5;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        SP_IDLE = 2'b00,
        SP_ADDR = 2'b01,
        SP_DATA = 2'b10,
        SP_DONE = 2'b11
    } sirx_ser_e;

    // Decoded receive words from the modem
    typedef struct packed {
        logic last;
        logic sized;
        logic crc_bad;
        logic wide;
        logic [15:0] lo;
        logic [15:0] hi;
    } sirx_rxent_s;

    // Received tone set
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [3:0] signalling_tone_high;
        logic [3:0] signalling_tone_low;
    } sirx_tset_s;

    // One-cycle event pulses from the signal processor
    typedef struct packed {
        logic inband_chg;
        logic ctcss_chg;
        logic dcs_chg;
        logic turnoff_chg;
        logic maint_chg;
        logic tset_sent;
        logic aux_high;
        logic aux_low;
        logic tx_last_bit;
        logic tx_xfer_req;
        logic sync_seen;
        logic head_ok;
        logic [1:0] rate;
        logic prog_done;
    } sirx_evt_s;
endpackage : sirx_pkg

/* File: src/sirx_fifo.sv */
// Receive word FIFO with valid and ready on both sides
`timescale 1ns/1ps
module sirx_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg;
    logic [AW:0] rd_reg;
    logic push;
    logic pop;

    // Full when pointers differ only in the wrap bit
    assign in_ready = !((wr_reg[AW] != rd_reg[AW]) &&
                        (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
    assign out_valid = (wr_reg != rd_reg);
    assign out_data = mem[rd_reg[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule : sirx_fifo

/* File: src/sirx_status_regs.sv */
// Status, interrupt and receive data registers behind the serial bus
// How it works
// - Aux result register holds last conversion, readable only when powered.
// - Status reads are valid only while the processor is powered.
// - A masked-in flag being set sets the pending bit 15; the CRC bit 5 never does.
// - Interrupt output active when pending bit and global enable both set.
// - Status read clears bits 15..1; bit 0 cleared only by program write.
// - Status bits 14, 2 and 1 always read zero.
// - Bits 13, 11, 10 flag tone changes in receive, zero in transmit.
// - Turn-off tone changes hit DCS flag; maintenance tone hits CTCSS.
// - Bit 12 set on matching tone set received, or fourth tone sent.
// - Bits 9 and 8 record high and low threshold crossings since read.
// - Receive: end bit with transfer bit after last part; CRC then too.
// - Transmit: end bit after last bit; formats 0,2,3 need host arm.
// - Bit 6 asks for transmit data or flags received data ready.
// - Bit 5 after sized type 4/5 CRC: zero if clean, else one.
// - Bits 4,3 give rate; loaded on sync or good-CRC head per type 0.
// - Program write clears the flag; completion sets it again.
// - Receive words hold latest bytes; unread data is overwritten.
// - High receive word used only for types 4, 5, frame heads and tone sets.
// - Tone set loads address and tones into high word if address matches and no receive word pops that cycle.
// - Head of type 3, 4 or 5 turns on automatic decoding.
`timescale 1ns/1ps
module sirx_status_regs (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic SER_CLK,
    input wire logic SER_CS_N,
    input wire logic SER_DIN,
    output logic SER_DOUT,
    output logic SER_DOUT_OE_N,
    output logic INTERRUPT_REQUEST_OUT_N,
    input wire logic POWER_ON,
    input wire logic RX_MODE,
    input wire logic TX_MODE,
    input wire logic TYPE0_ENABLE,
    input wire logic [2:0] DATA_FORMAT,
    input wire logic END_ARMED,
    input wire sirx_pkg::sirx_evt_s EVENTS,
    input wire logic [7:0] AUX_RESULT,
    input wire logic AUX_VALID,
    input wire sirx_pkg::sirx_rxent_s RX_ENTRY,
    input wire logic RX_ENTRY_VALID,
    output logic RX_ENTRY_READY,
    input wire sirx_pkg::sirx_tset_s TONESET,
    input wire logic [7:0] DEVICE_ADDR,
    input wire logic HEAD_VALID,
    input wire logic [2:0] HEAD_TYPE,
    output logic AUTO_DECODE,
    output logic [15:0] PROG_WORD,
    output logic PROG_STROBE
);
    import sirx_pkg::*;

    // Registers readable over the serial bus
    function automatic logic is_read(input logic [7:0] a);
        return (a == ADDR_AUX) || (a == ADDR_STAT) ||
               (a == ADDR_RXLO) || (a == ADDR_RXHI);
    endfunction : is_read

    // Value shifted out for a read, left aligned
    function automatic logic [15:0] rd_value(input logic [7:0] a,
        input logic pwr, input logic [15:0] st, input logic [7:0] ax,
        input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] v;
        v = 16'h0000;
        case (a)
            ADDR_AUX: v = pwr ? {ax, 8'h00} : 16'h0000;
            ADDR_STAT: v = pwr ? st : 16'h0000;
            ADDR_RXLO: v = lo;
            ADDR_RXHI: v = hi;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction : rd_value

    logic sclk_s1, sclk_s2, sclk_s3;
    logic cs_s1, cs_s2;
    logic din_s1, din_s2;
    logic sclk_rise, sclk_fall;
    sirx_ser_e ser_reg;
    logic [4:0] cnt_reg;
    logic [7:0] addr_reg;
    logic [15:0] sin_reg;
    logic [15:0] sout_reg;
    logic dout_reg;
    logic [15:0] stat_reg, stat_next;
    logic [15:0] mask_reg;
    logic [7:0] aux_reg;
    logic [15:0] rxlo_reg, rxhi_reg;
    logic irq_n_reg;
    logic auto_reg;
    logic [15:0] prog_reg;
    logic prog_wr;
    logic rd_clr;
    logic frame_end;
    logic [4:0] end_cnt;
    logic [15:0] set_vec;
    logic rate_ld, crc_ld, tset_hit, end_auto;
    sirx_rxent_s ent;
    logic ent_valid, ent_ready, pop;

    // Pin synchronisers, edges taken from second and third stages
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
        end
        else
        begin
            sclk_s1 <= SER_CLK;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            cs_s1 <= SER_CS_N;
            cs_s2 <= cs_s1;
            din_s1 <= SER_DIN;
            din_s2 <= din_s1;
        end
    end

    assign sclk_rise = sclk_s2 && !sclk_s3;
    assign sclk_fall = !sclk_s2 && sclk_s3;
    assign end_cnt = (addr_reg == ADDR_AUX) ? CNT_BYTE : CNT_WORD;
    assign frame_end = (ser_reg == SP_DATA) && sclk_rise &&
                       (cnt_reg + 5'h01 == end_cnt);

    // One register per transaction; extra clocks ignored until deselect
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ser_reg <= SP_IDLE;
            cnt_reg <= 5'h00;
            addr_reg <= 8'h00;
            sin_reg <= 16'h0000;
        end
        else if (cs_s2)
        begin
            ser_reg <= SP_IDLE;
            cnt_reg <= 5'h00;
        end
        else
        begin
            case (ser_reg)
                SP_IDLE: ser_reg <= SP_ADDR;
                SP_ADDR:
                begin
                    if (sclk_rise)
                    begin
                        sin_reg <= {sin_reg[14:0], din_s2};
                        cnt_reg <= cnt_reg + 5'h01;
                        if (cnt_reg + 5'h01 == CNT_ADDR)
                        begin
                            addr_reg <= {sin_reg[6:0], din_s2};
                            ser_reg <= SP_DATA;
                        end
                    end
                end
                SP_DATA:
                begin
                    if (sclk_rise)
                    begin
                        sin_reg <= {sin_reg[14:0], din_s2};
                        cnt_reg <= cnt_reg + 5'h01;
                        if (frame_end)
                        begin
                            ser_reg <= SP_DONE;
                        end
                    end
                end
                SP_DONE: ser_reg <= SP_DONE;
                default: ser_reg <= SP_IDLE;
            endcase
        end
    end

    // Read data: loaded at end of address, changes on falling edges
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            sout_reg <= 16'h0000;
            dout_reg <= 1'b0;
        end
        else if (ser_reg == SP_ADDR && sclk_rise &&
                 cnt_reg + 5'h01 == CNT_ADDR)
        begin
            sout_reg <= rd_value({sin_reg[6:0], din_s2}, POWER_ON,
                stat_reg, aux_reg, rxlo_reg, rxhi_reg);
        end
        else if (ser_reg == SP_DATA && sclk_fall)
        begin
            dout_reg <= sout_reg[15];
            sout_reg <= {sout_reg[14:0], 1'b0};
        end
    end

    assign SER_DOUT = dout_reg;
    assign SER_DOUT_OE_N = !(ser_reg == SP_DATA && is_read(addr_reg));
    assign rd_clr = frame_end && (addr_reg == ADDR_STAT);
    assign prog_wr = frame_end && (addr_reg == ADDR_PROG);

    // Mask and programming word writes
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            mask_reg <= MASK_RST;
            prog_reg <= WORD_RST;
            PROG_STROBE <= 1'b0;
        end
        else
        begin
            PROG_STROBE <= prog_wr;
            if (frame_end && addr_reg == ADDR_MASK)
            begin
                mask_reg <= {sin_reg[14:0], din_s2};
            end
            if (prog_wr)
            begin
                prog_reg <= {sin_reg[14:0], din_s2};
            end
        end
    end

    assign PROG_WORD = prog_reg;

    // Receive word buffer, held back while a low or high receive word is shifting out
    sirx_fifo #(
        .WIDTH($bits(sirx_rxent_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK),
        .arst_n(ARST_N),
        .in_data(RX_ENTRY),
        .in_valid(RX_ENTRY_VALID),
        .in_ready(RX_ENTRY_READY),
        .out_data(ent),
        .out_valid(ent_valid),
        .out_ready(ent_ready)
    );

    assign ent_ready = !(ser_reg == SP_DATA &&
        (addr_reg == ADDR_RXLO || addr_reg == ADDR_RXHI));
    assign pop = ent_valid && ent_ready;
    assign tset_hit = RX_MODE && !TX_MODE && TONESET.valid &&
        (TONESET.addr == DEVICE_ADDR || TONESET.addr == ALL_CALL);

    // Receive words: low word overwritten by each new arrival, high word by wide arrivals or, in a cycle with no arrival, a matching tone set
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rxlo_reg <= WORD_RST;
            rxhi_reg <= WORD_RST;
        end
        else if (pop)
        begin
            rxlo_reg <= ent.lo;
            if (ent.wide)
            begin
                rxhi_reg <= ent.hi;
            end
        end
        else if (tset_hit)
        begin
            rxhi_reg <= {TONESET.signalling_tone_high,
                TONESET.signalling_tone_low, TONESET.addr};
        end
    end

    // Aux converter result
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            aux_reg <= AUX_RST;
        end
        else if (AUX_VALID)
        begin
            aux_reg <= AUX_RESULT;
        end
    end

    // Automatic decode of formatted frames
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            auto_reg <= 1'b0;
        end
        else if (HEAD_VALID)
        begin
            auto_reg <= (HEAD_TYPE == FMT_3 || HEAD_TYPE == FMT_4 ||
                         HEAD_TYPE == FMT_5);
        end
        else if (pop && ent.last)
        begin
            auto_reg <= 1'b0;
        end
    end

    assign AUTO_DECODE = auto_reg;
    assign end_auto = !(DATA_FORMAT == FMT_0 || DATA_FORMAT == FMT_2 ||
                        DATA_FORMAT == FMT_3);
    assign rate_ld = RX_MODE && !TX_MODE &&
        (TYPE0_ENABLE ? EVENTS.sync_seen : EVENTS.head_ok);
    assign crc_ld = RX_MODE && !TX_MODE && pop &&
        ent.last && ent.sized;

    // Flag set terms from events
    always_comb
    begin
        set_vec = 16'h0000;
        if (RX_MODE && !TX_MODE)
        begin
            set_vec[B_INB] = EVENTS.inband_chg;
            set_vec[B_CTC] = EVENTS.ctcss_chg || EVENTS.maint_chg;
            set_vec[B_DCS] = EVENTS.dcs_chg || EVENTS.turnoff_chg;
            set_vec[B_END] = pop && ent.last;
            set_vec[B_XFER] = pop;
        end
        else if (TX_MODE)
        begin
            set_vec[B_END] = EVENTS.tx_last_bit &&
                             (end_auto || END_ARMED);
            set_vec[B_XFER] = EVENTS.tx_xfer_req;
        end
        set_vec[B_TSET] = TX_MODE ? EVENTS.tset_sent : tset_hit;
        set_vec[B_AHI] = EVENTS.aux_high;
        set_vec[B_ALO] = EVENTS.aux_low;
        set_vec[B_R24] = rate_ld && EVENTS.rate[1];
        set_vec[B_R12] = rate_ld && EVENTS.rate[0];
        set_vec[B_PROG] = EVENTS.prog_done && !stat_reg[B_PROG];
    end

    // Status next value; new events win over the read clear
    always_comb
    begin
        stat_next = stat_reg & ~(rd_clr ? CLEAR_ON_READ : 16'h0000);
        stat_next = stat_next | set_vec;
        if (crc_ld)
        begin
            stat_next[B_CRC] = ent.crc_bad;
        end
        if (rate_ld)
        begin
            stat_next[B_R24:B_R12] = EVENTS.rate;
        end
        if (prog_wr)
        begin
            stat_next[B_PROG] = 1'b0;
        end
        if (EVENTS.prog_done)
        begin
            stat_next[B_PROG] = 1'b1;
        end
        if (TX_MODE)
        begin
            stat_next = stat_next & ~TONE_FLAGS;
        end
        if ((set_vec & mask_reg & CLEAR_ON_READ & ~16'h8000) != 16'h0000 ||
            (set_vec[B_PROG] && mask_reg[B_PROG]))
        begin
            stat_next[B_IRQ] = 1'b1;
        end
        stat_next = stat_next & ~RSVD_MASK;
    end

    // Status register and registered active-low interrupt
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            stat_reg <= STAT_RST;
            irq_n_reg <= 1'b1;
        end
        else
        begin
            stat_reg <= stat_next;
            irq_n_reg <= !(stat_reg[B_IRQ] && mask_reg[B_IRQ]);
        end
    end

    assign INTERRUPT_REQUEST_OUT_N = irq_n_reg;

    sequence s_pop_last;
        pop && RX_MODE && !TX_MODE && ent.last;
    endsequence

    sequence s_flags_end;
        stat_reg[B_END] && stat_reg[B_XFER];
    endsequence

    chk_irq_out_low: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        (stat_reg[B_IRQ] && mask_reg[B_IRQ]) |=> !INTERRUPT_REQUEST_OUT_N)
        else $error("interrupt output not asserted");
    chk_irq_out_high: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        !(stat_reg[B_IRQ] && mask_reg[B_IRQ]) |=> INTERRUPT_REQUEST_OUT_N)
        else $error("interrupt output stuck active");
    chk_read_clears: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        rd_clr && !TX_MODE |=>
        ((stat_reg & ~$past(set_vec) & CLEAR_ON_READ & ~16'h8038) == 16'h0000))
        else $error("status read did not clear flags");
    chk_rsvd_zero: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        (stat_reg & RSVD_MASK) == 16'h0000)
        else $error("reserved status bit set");
    chk_tx_tone_zero: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        TX_MODE |=> (stat_reg & TONE_FLAGS) == 16'h0000)
        else $error("tone flag set in transmit");
    chk_prog_clear: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        prog_wr && !EVENTS.prog_done |=> !stat_reg[B_PROG] && PROG_STROBE)
        else $error("program write did not clear flag");
    chk_irq_on_flag: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        (set_vec[B_INB] && mask_reg[B_INB]) ||
        (set_vec[B_AHI] && mask_reg[B_AHI]) |=> stat_reg[B_IRQ])
        else $error("pending bit not set on masked event");
    chk_aux_hist: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        EVENTS.aux_low |=> stat_reg[B_ALO])
        else $error("low threshold history lost");
    chk_end_with_xfer: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        s_pop_last |=> s_flags_end)
        else $error("end and transfer flags not set together");
    chk_toneset_addr: assert property (
        @(posedge CLK) disable iff (!ARST_N)
        TONESET.valid && !tset_hit && !pop |=> $stable(rxhi_reg))
        else $error("high word updated by foreign tone set");
endmodule : sirx_status_regs

/* File: test/sirx_host.sv */
// Serial bus host model that frames register reads and writes
`timescale 1ns/1ps
module sirx_host (
    output logic ser_clk,
    output logic ser_cs_n,
    output logic ser_din,
    input wire logic ser_dout,
    input wire logic ser_dout_oe_n
);
    // Idle bus: select high, clock parked low
    initial
    begin
        ser_clk = 1'b0;
        ser_cs_n = 1'b1;
        ser_din = 1'b0;
    end

    // One register per frame, address byte then data, MSB first
    task automatic xfer(input logic [7:0] a, input logic [15:0] d,
        input int n, output logic [15:0] q);
        logic [23:0] f;
        f = (n == 8) ? {a, d[7:0], 8'h00} : {a, d};
        q = '0;
        #5; // Keep link edges off the system clock edge
        ser_cs_n = 1'b0;
        #100;
        for (int i = 0; i < 8 + n; i++)
        begin
            ser_clk = 1'b0;
            ser_din = f[23 - i];
            #125;
            if (i >= 8)
                // Undriven data line floats high
                q = {q[14:0], ser_dout_oe_n ? 1'b1 : ser_dout};
            ser_clk = 1'b1;
            #75;
        end
        ser_clk = 1'b0;
        ser_din = ~ser_din; // Released line shows no stale value
        #125;
        ser_cs_n = 1'b1;
        #200;
    endtask : xfer
endmodule : sirx_host

/* File: test/tb_top.sv */
// Self-checking bench for the status and receive data registers
`timescale 1ns/1ps
module tb_top;
    import sirx_pkg::*;
    logic clk = 0;
    logic arst_n = 0;
    logic pwr = 1, rxm = 1, txm = 0, t0 = 0, arm = 0, hv = 0, av = 0;
    logic ent_v = 0;
    logic [2:0] fmt = FMT_0;
    logic [2:0] htype = 3'h0;
    logic [7:0] aux = 8'h00;
    logic [7:0] dev = 8'h33;
    sirx_evt_s evt = '0;
    sirx_rxent_s ent = '0;
    sirx_tset_s ts = '0;
    logic ready, oe_n, irq_n, dout, sclk, cs_n, din, auto, pstb;
    logic [15:0] pword;
    logic [2:0] fl [4] = '{FMT_0, FMT_2, FMT_3, FMT_4};
    int n_mismatch = 0;
    int checked = 0;

    // 40 MHz system clock
    initial
    begin
        forever #12.5 clk = ~clk;
    end

    sirx_host sirx_host_i (.ser_clk(sclk), .ser_cs_n(cs_n), .ser_din(din),
        .ser_dout(dout), .ser_dout_oe_n(oe_n));

    sirx_status_regs sirx_status_regs_i (.CLK(clk), .ARST_N(arst_n),
        .SER_CLK(sclk), .SER_CS_N(cs_n), .SER_DIN(din), .SER_DOUT(dout),
        .SER_DOUT_OE_N(oe_n), .INTERRUPT_REQUEST_OUT_N(irq_n),
        .POWER_ON(pwr), .RX_MODE(rxm), .TX_MODE(txm), .TYPE0_ENABLE(t0),
        .DATA_FORMAT(fmt), .END_ARMED(arm), .EVENTS(evt), .AUX_RESULT(aux),
        .AUX_VALID(av), .RX_ENTRY(ent), .RX_ENTRY_VALID(ent_v),
        .RX_ENTRY_READY(ready), .TONESET(ts), .DEVICE_ADDR(dev),
        .HEAD_VALID(hv), .HEAD_TYPE(htype), .AUTO_DECODE(auto),
        .PROG_WORD(pword), .PROG_STROBE(pstb));

    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task automatic rd(input logic [7:0] a, input int n,
        input logic [15:0] exp);
        logic [15:0] q;
        sirx_host_i.xfer(a, 16'h0000, n, q);
        @(posedge clk);
        cmp(q, exp);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        sirx_host_i.xfer(a, d, 16, q);
        @(posedge clk);
    endtask : wr

    task automatic pulse(input sirx_evt_s e);
        evt <= e;
        @(posedge clk);
        evt <= '0;
        repeat (3) @(posedge clk);
    endtask : pulse

    task automatic ev(input sirx_evt_s e, input logic [15:0] exp);
        pulse(e);
        rd(ADDR_STAT, 16, exp);
    endtask : ev

    task automatic tone(input logic [7:0] a, input logic [15:0] es);
        ts <= '{1'b1, a, 4'hA, 4'h5};
        @(posedge clk);
        ts <= '0;
        repeat (3) @(posedge clk);
        rd(ADDR_STAT, 16, es);
    endtask : tone

    task automatic push(input sirx_rxent_s e);
        bit ok;
        ok = 0;
        ent <= e;
        ent_v <= 1;
        for (int i = 0; i < 20 && !ok; i++)
        begin
            @(negedge clk);
            ok = (ready === 1'b1);
            @(posedge clk);
        end
        ent_v <= 0;
        @(posedge clk); // Gap so a next call never rewrites valid
        if (!ok)
        begin
            n_mismatch++;
            print_verdict();
        end
    endtask : push

    task automatic fin(input string s);
        $display("test %s done", s);
    endtask : fin

    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        arst_n <= 1;
        repeat (2) @(posedge clk);
        rd(ADDR_STAT, 16, STAT_RST);
        rd(8'hC0, 16, 16'hFFFF);
        aux <= 8'hA5;
        av <= 1;
        @(posedge clk);
        av <= 0;
        pwr <= 0;
        rd(ADDR_AUX, 8, 16'h0000);
        rd(ADDR_STAT, 16, 16'h0000);
        pwr <= 1;
        rd(ADDR_AUX, 8, 16'h00A5);
        fin("reset_aux");
        ev('{aux_high: 1, aux_low: 1, default: 0}, 16'h0301);
        ev('{aux_low: 1, default: 0}, 16'h0101);
        rd(ADDR_STAT, 16, STAT_RST);
        for (int g = 0; g < 2; g++)
        begin
            wr(ADDR_MASK, g ? 16'h2000 : 16'hA000);
            pulse('{inband_chg: 1, default: 0});
            cmp({15'h0, irq_n}, g ? 16'h1 : 16'h0);
            rd(ADDR_STAT, 16, 16'hA001);
            repeat (3) @(posedge clk);
            cmp({15'h0, irq_n}, 16'h1);
        end
        wr(ADDR_MASK, MASK_RST);
        ev('{turnoff_chg: 1, default: 0}, 16'h0401);
        ev('{maint_chg: 1, default: 0}, 16'h0801);
        ev('{ctcss_chg: 1, default: 0}, 16'h0801);
        fin("irq_tones");
        rxm <= 0;
        txm <= 1;
        ev('{inband_chg: 1, ctcss_chg: 1, dcs_chg: 1, default: 0},
            STAT_RST);
        ev('{tset_sent: 1, default: 0}, 16'h1001);
        ev('{tx_xfer_req: 1, default: 0}, 16'h0041);
        for (int k = 0; k < 4; k++)
        begin
            fmt <= fl[k];
            ev('{tx_last_bit: 1, default: 0},
                k == 3 ? 16'h0081 : STAT_RST);
        end
        fmt <= FMT_2;
        arm <= 1;
        ev('{tx_last_bit: 1, default: 0}, 16'h0081);
        txm <= 0;
        wr(ADDR_PROG, 16'h8123);
        cmp(pword, 16'h8123);
        rd(ADDR_STAT, 16, 16'h0000);
        ev('{prog_done: 1, default: 0}, STAT_RST);
        fin("tx_prog");
        rxm <= 1;
        t0 <= 1;
        ev('{sync_seen: 1, rate: 2'b10, default: 0}, 16'h0011);
        t0 <= 0;
        ev('{sync_seen: 1, rate: 2'b01, default: 0}, STAT_RST);
        ev('{head_ok: 1, rate: 2'b01, default: 0}, 16'h0009);
        push('{lo: 16'h1111, default: 0});
        push('{1'b1, 1'b1, 1'b1, 1'b1, 16'h2222, 16'h3344});
        repeat (3) @(posedge clk);
        rd(ADDR_STAT, 16, 16'h00E1);
        rd(ADDR_RXLO, 16, 16'h2222);
        rd(ADDR_RXHI, 16, 16'h3344);
        push('{last: 1, sized: 1, lo: 16'h5566, default: 0});
        repeat (3) @(posedge clk);
        rd(ADDR_STAT, 16, 16'h00C1);
        rd(ADDR_RXHI, 16, 16'h3344);
        fin("rx_data");
        tone(8'h12, STAT_RST);
        rd(ADDR_RXHI, 16, 16'h3344);
        tone(ALL_CALL, 16'h1001);
        rd(ADDR_RXHI, 16, 16'hA540);
        tone(8'h33, 16'h1001);
        rd(ADDR_RXHI, 16, 16'hA533);
        for (int k = 1; k < 6; k += 2)
        begin
            htype <= 3'(k);
            hv <= 1;
            @(posedge clk);
            hv <= 0;
            repeat (3) @(posedge clk);
            cmp({15'h0, auto}, {15'h0, k != 1});
        end
        fin("tone_head");
        print_verdict();
    end
endmodule : tb_top
